// [sbsr_host_model.sv]
// Remote controller model: commands, enable writes, queries and serial polls
`timescale 1ns/10ps
module sbsr_host_model
  import sbsr_pkg::*;
(
  input  wire logic        clk,
  output sbsr_cmd_t        cmd,
  output logic             wrEn,
  output sbsr_sel_t        wrSel,
  output logic      [15:0] wrData,
  output logic             rdEn,
  output sbsr_sel_t        rdSel,
  output logic             serialPoll,
  input  wire logic [15:0] rdData,
  input  wire logic [7:0]  pollByte
);
  initial begin
    cmd = '0;
    wrEn = 1'b0;
    wrSel = SEL_STB;
    wrData = 16'h0000;
    rdEn = 1'b0;
    rdSel = SEL_STB;
    serialPoll = 1'b0;
  end

  // Data bus shows the inverted value once released so stale values cannot pass
  task automatic write_reg(input sbsr_sel_t sel, input logic [15:0] val);
    @(negedge clk);
    wrEn = 1'b1;
    wrSel = sel;
    wrData = val;
    @(negedge clk);
    wrEn = 1'b0;
    wrData = ~val;
  endtask : write_reg

  task automatic read_reg(input sbsr_sel_t sel, output logic [15:0] got);
    @(negedge clk);
    rdEn = 1'b1;
    rdSel = sel;
    @(negedge clk);
    rdEn = 1'b0;
    got = rdData;
  endtask : read_reg

  task automatic poll(output logic [7:0] got);
    @(negedge clk);
    serialPoll = 1'b1;
    @(negedge clk);
    serialPoll = 1'b0;
    got = pollByte;
  endtask : poll

  task automatic pulse(input logic [5:0] c);
    @(negedge clk);
    cmd = c;
    @(negedge clk);
    cmd = '0;
  endtask : pulse
endmodule : sbsr_host_model

// [sbsr_pkg.sv]
// Package: constants, selectors and carrier types for the status byte block
package sbsr_pkg;

  localparam int SBSR_REG_W   = 16;
  localparam int SBSR_BYTE_W  = 8;
  localparam int SBSR_TOP_BIT = 15;

  // Status byte bit positions
  localparam int SB_MEAS  = 0;
  localparam int SB_UNUSD = 1;
  localparam int SB_ERRQ  = 2;
  localparam int SB_QUES  = 3;
  localparam int SB_OUTQ  = 4;
  localparam int SB_STD   = 5;
  localparam int SB_SUMM  = 6;
  localparam int SB_OPER  = 7;

  localparam logic [15:0] SBSR_REG_RST  = 16'h0000;
  localparam logic [7:0]  SBSR_BYTE_RST = 8'h00;
  localparam logic [15:0] SBSR_TOP_MASK = 16'h7FFF;
  localparam logic [7:0]  SBSR_SUM_MASK = 8'hBD;

  // Register selector for writes and queries
  typedef enum logic [3:0] {
    SEL_STD_EVT  = 4'h0,
    SEL_STD_ENA  = 4'h1,
    SEL_OPR_COND = 4'h2,
    SEL_OPR_EVT  = 4'h3,
    SEL_OPR_ENA  = 4'h4,
    SEL_MEA_COND = 4'h5,
    SEL_MEA_EVT  = 4'h6,
    SEL_MEA_ENA  = 4'h7,
    SEL_QUE_COND = 4'h8,
    SEL_QUE_EVT  = 4'h9,
    SEL_QUE_ENA  = 4'hA,
    SEL_STB      = 4'hB,
    SEL_SRE      = 4'hC
  } sbsr_sel_t;

  // One-cycle command strobes
  typedef struct packed {
    logic clearStatus;
    logic statusPreset;
    logic queueClear;
    logic systemClear;
    logic resetCmd;
    logic systemPreset;
  } sbsr_cmd_t;

  // Event sources for the four register sets
  typedef struct packed {
    logic [15:0] stdEvent;
    logic [15:0] operCond;
    logic [15:0] operEvent;
    logic [15:0] measCond;
    logic [15:0] measEvent;
    logic [15:0] quesCond;
    logic [15:0] quesEvent;
  } sbsr_src_t;

endpackage : sbsr_pkg

// [sbsr_status_byte.sv]
// Module: status registers, status byte and service request generation
`timescale 1ns/10ps

// Functional notes
// - Power-on clears every status register; both queues start empty.
// - Reset and system preset commands leave status registers and queues alone.
// - Clear-status zeroes standard, operation, measurement and questionable event registers.
// - Status preset zeroes operation, measurement and questionable enable registers.
// - Standard enable register changes only by its own write.
// - Error queue empties on clear-status, queue clear, system clear; not preset.
// - Writing zero to an enable register clears all its bits.
// - Only enable registers are writable; all others are read-only.
// - Write value is binary-weighted, bit n worth two to the n, 16 bits.
// - Top bit of every 16-bit status register reads zero.
// - Queries return register contents as binary-weighted value.
// - Service request uses an 8-bit status byte and 8-bit mask.
// - Status byte summary bits follow their sources, no latching.
// - Reading standard event register clears it, dropping its summary bit.
// - Byte bits: 0 meas, 2 errq, 3 ques, 4 outq, 5 std, 7 oper.
// - Bit 6 set while any enabled summary bit is set.
// - Bit 6 is request flag on serial poll, master summary on query.
// - Bit 6 is OR of summary bits ANDed with mask bits.
// - Mask clears on power cycle and on write of zero.
// - Mask is writable and readable back by the host.
// - Serial poll clears request flag; master summary stays while cause stays.
// - Enabled summary rising sets request flag and asserts service request.
// - Event bits latch at one until their register is reset.
// - Mask accepts 0 to 255; unaffected by clear-status and status preset.
module sbsr_status_byte
  import sbsr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire sbsr_cmd_t   cmd,
  input  wire sbsr_src_t   src,
  input  wire logic        errQueuePush,
  input  wire logic        outQueueNonEmpty,
  input  wire logic        wrEn,
  input  wire sbsr_sel_t   wrSel,
  input  wire logic [15:0] wrData,
  input  wire logic        rdEn,
  input  wire sbsr_sel_t   rdSel,
  input  wire logic        serialPoll,
  output logic      [15:0] rdData,
  output logic      [7:0]  pollByte,
  output logic             srqOut,
  output logic             errQueueNonEmpty
);

  logic rstMeta, rstSync, rst_n;

  // Reset release through two flops so all state leaves reset on one edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end
  assign rst_n = rstSync;

  logic [15:0] stdEvt, stdEna, oprEvt, oprEna, meaEvt, meaEna, queEvt, queEna;
  logic [15:0] next_stdEvt, next_stdEna, next_oprEvt, next_oprEna;
  logic [15:0] next_meaEvt, next_meaEna, next_queEvt, next_queEna;
  logic [7:0]  srMask, next_srMask;
  logic        errFlag, next_errFlag;
  logic        rqs, next_rqs;
  logic [7:0]  enSum, sumPrev, next_sumPrev;
  logic [7:0]  stbQuery, pollView;
  logic        sumRise;
  logic [15:0] next_rdData;
  logic [7:0]  next_pollByte;
  logic [7:0]  stb;
  logic        mss;
  logic        wrDataSafe;
  logic        evtClear, errClear;

  // Commands that must not touch status state are only carried for visibility
  assign wrDataSafe = cmd.resetCmd | cmd.systemPreset;
  assign evtClear   = cmd.clearStatus;
  assign errClear   = cmd.clearStatus | cmd.queueClear | cmd.systemClear;

  // Summary messages; combinational so they fall the cycle a source clears
  always_comb begin
    stb           = SBSR_BYTE_RST;
    stb[SB_MEAS]  = |(meaEvt & meaEna);
    stb[SB_UNUSD] = 1'b0;
    stb[SB_ERRQ]  = errFlag;
    stb[SB_QUES]  = |(queEvt & queEna);
    stb[SB_OUTQ]  = outQueueNonEmpty;
    stb[SB_STD]   = |(stdEvt & stdEna);
    stb[SB_OPER]  = |(oprEvt & oprEna);
    // Mask bit 6 cannot feed back since the summary mask drops it
    enSum         = stb & srMask & SBSR_SUM_MASK;
    mss           = |enSum;
    // Each enabled bit is edge-checked on its own, so a second cause still requests
    sumRise       = |(enSum & ~sumPrev);
    // Bit 6 means master summary on a query but request flag on a poll
    stbQuery          = stb;
    stbQuery[SB_SUMM] = mss;
    pollView          = stb;
    pollView[SB_SUMM] = rqs;
  end

  // Register state
  always_comb begin
    next_stdEvt   = (stdEvt | src.stdEvent) & SBSR_TOP_MASK;
    next_oprEvt   = (oprEvt | src.operEvent) & SBSR_TOP_MASK;
    next_meaEvt   = (meaEvt | src.measEvent) & SBSR_TOP_MASK;
    next_queEvt   = (queEvt | src.quesEvent) & SBSR_TOP_MASK;
    next_stdEna   = stdEna;
    next_oprEna   = oprEna;
    next_meaEna   = meaEna;
    next_queEna   = queEna;
    next_srMask   = srMask;
    next_errFlag  = errFlag;
    if (evtClear) begin
      // Events in the clear cycle survive; set wins so none is ever lost
      next_stdEvt = src.stdEvent & SBSR_TOP_MASK;
      next_oprEvt = src.operEvent & SBSR_TOP_MASK;
      next_meaEvt = src.measEvent & SBSR_TOP_MASK;
      next_queEvt = src.quesEvent & SBSR_TOP_MASK;
    end else if (rdEn && rdSel == SEL_STD_EVT) begin
      // Events arriving in the read cycle survive the clear
      next_stdEvt = src.stdEvent & SBSR_TOP_MASK;
    end
    if (cmd.statusPreset) begin
      next_oprEna = SBSR_REG_RST;
      next_meaEna = SBSR_REG_RST;
      next_queEna = SBSR_REG_RST;
    end
    // Only enable registers accept writes; value is taken bit-weighted
    if (wrEn) begin
      case (wrSel)
        SEL_STD_ENA: next_stdEna = wrData & SBSR_TOP_MASK;
        SEL_OPR_ENA: next_oprEna = wrData & SBSR_TOP_MASK;
        SEL_MEA_ENA: next_meaEna = wrData & SBSR_TOP_MASK;
        SEL_QUE_ENA: next_queEna = wrData & SBSR_TOP_MASK;
        SEL_SRE:     next_srMask = wrData[SBSR_BYTE_W-1:0];
        default:     next_srMask = srMask;
      endcase
    end
    // Push wins over clear so a new message is not lost
    if (errClear) begin
      next_errFlag = 1'b0;
    end
    if (errQueuePush) begin
      next_errFlag = 1'b1;
    end
  end

  // Request flag: set on an enabled summary rising, cleared by serial poll
  always_comb begin
    next_sumPrev  = enSum;
    next_rqs      = rqs;
    if (serialPoll) begin
      next_rqs = 1'b0;
    end
    if (sumRise) begin
      next_rqs = 1'b1;
    end
  end

  // Read data path
  always_comb begin
    next_rdData   = rdData;
    next_pollByte = pollByte;
    if (serialPoll) begin
      next_pollByte = pollView;
    end
    if (rdEn) begin
      case (rdSel)
        SEL_STD_EVT:  next_rdData = stdEvt;
        SEL_STD_ENA:  next_rdData = stdEna;
        SEL_OPR_COND: next_rdData = src.operCond & SBSR_TOP_MASK;
        SEL_OPR_EVT:  next_rdData = oprEvt;
        SEL_OPR_ENA:  next_rdData = oprEna;
        SEL_MEA_COND: next_rdData = src.measCond & SBSR_TOP_MASK;
        SEL_MEA_EVT:  next_rdData = meaEvt;
        SEL_MEA_ENA:  next_rdData = meaEna;
        SEL_QUE_COND: next_rdData = src.quesCond & SBSR_TOP_MASK;
        SEL_QUE_EVT:  next_rdData = queEvt;
        SEL_QUE_ENA:  next_rdData = queEna;
        SEL_STB:      next_rdData = {SBSR_BYTE_RST, stbQuery};
        SEL_SRE:      next_rdData = {SBSR_BYTE_RST, srMask};
        default:      next_rdData = SBSR_REG_RST;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stdEvt   <= SBSR_REG_RST;
      stdEna   <= SBSR_REG_RST;
      oprEvt   <= SBSR_REG_RST;
      oprEna   <= SBSR_REG_RST;
      meaEvt   <= SBSR_REG_RST;
      meaEna   <= SBSR_REG_RST;
      queEvt   <= SBSR_REG_RST;
      queEna   <= SBSR_REG_RST;
      srMask   <= SBSR_BYTE_RST;
      errFlag  <= 1'b0;
      rqs      <= 1'b0;
      sumPrev  <= SBSR_BYTE_RST;
      rdData   <= SBSR_REG_RST;
      pollByte <= SBSR_BYTE_RST;
    end else begin
      stdEvt   <= next_stdEvt;
      stdEna   <= next_stdEna;
      oprEvt   <= next_oprEvt;
      oprEna   <= next_oprEna;
      meaEvt   <= next_meaEvt;
      meaEna   <= next_meaEna;
      queEvt   <= next_queEvt;
      queEna   <= next_queEna;
      srMask   <= next_srMask;
      errFlag  <= next_errFlag;
      rqs      <= next_rqs;
      sumPrev  <= next_sumPrev;
      rdData   <= next_rdData;
      pollByte <= next_pollByte;
    end
  end

  assign srqOut           = rqs;
  assign errQueueNonEmpty = errFlag;

  a_event_latch: assert property (@(posedge clk) disable iff (!rst_n)
    src.operEvent[0] |=> oprEvt[0])
    else $error("operation event bit did not latch");

  a_clear_status: assert property (@(posedge clk) disable iff (!rst_n)
    evtClear |=> oprEvt == ($past(src.operEvent) & SBSR_TOP_MASK))
    else $error("clear status left event bits");

  a_preset_enables: assert property (@(posedge clk) disable iff (!rst_n)
    (cmd.statusPreset && !wrEn) |=> (meaEna == 16'h0000 && oprEna == 16'h0000))
    else $error("status preset left enable bits");

  a_std_ena_kept: assert property (@(posedge clk) disable iff (!rst_n)
    (!wrEn) |=> $stable(stdEna))
    else $error("standard enable changed without write");

  a_mask_kept: assert property (@(posedge clk) disable iff (!rst_n)
    (!(wrEn && wrSel == SEL_SRE)) |=> $stable(srMask))
    else $error("service request mask changed without write");

  a_top_bit_zero: assert property (@(posedge clk) disable iff (!rst_n)
    rdData[SBSR_TOP_BIT] == 1'b0)
    else $error("top status bit read as one");

  a_summary_or: assert property (@(posedge clk) disable iff (!rst_n)
    (rdEn && rdSel == SEL_STB) |=> rdData[SB_SUMM] == $past(
      (stb[SB_MEAS] & srMask[SB_MEAS]) | (stb[SB_ERRQ] & srMask[SB_ERRQ]) |
      (stb[SB_QUES] & srMask[SB_QUES]) | (stb[SB_OUTQ] & srMask[SB_OUTQ]) |
      (stb[SB_STD] & srMask[SB_STD]) | (stb[SB_OPER] & srMask[SB_OPER])))
    else $error("master summary mismatch");

  a_rqs_rise: assert property (@(posedge clk) disable iff (!rst_n)
    sumRise |=> srqOut)
    else $error("request not raised on summary rise");

  a_poll_clears: assert property (@(posedge clk) disable iff (!rst_n)
    (serialPoll && !sumRise) |=> !srqOut)
    else $error("serial poll did not clear request");

  a_std_read_clr: assert property (@(posedge clk) disable iff (!rst_n)
    (rdEn && rdSel == SEL_STD_EVT && src.stdEvent == 16'h0000) |=> stdEvt == 16'h0000)
    else $error("standard event read did not clear");

  a_err_queue: assert property (@(posedge clk) disable iff (!rst_n)
    (errClear && !errQueuePush) |=> !errQueueNonEmpty)
    else $error("error queue not emptied");

  a_unchanged_rst: assert property (@(posedge clk) disable iff (!rst_n)
    (wrDataSafe && !wrEn && !cmd.statusPreset) |=> $stable(srMask) && $stable(queEna))
    else $error("reset command disturbed status state");

  // Host-visible views of the status byte and the request flag
  a_query_unused: assert property (@(posedge clk) disable iff (!rst_n)
    (rdEn && rdSel == SEL_STB)
      |=> (rdData[SB_UNUSD] == 1'b0 && rdData[SBSR_REG_W-1:SBSR_BYTE_W] == SBSR_BYTE_RST))
    else $error("unused status byte bits read as one");

  a_query_errq: assert property (@(posedge clk) disable iff (!rst_n)
    (rdEn && rdSel == SEL_STB) |=> rdData[SB_ERRQ] == $past(errQueueNonEmpty))
    else $error("error queue summary wrong in status byte");

  a_query_outq: assert property (@(posedge clk) disable iff (!rst_n)
    (rdEn && rdSel == SEL_STB) |=> rdData[SB_OUTQ] == $past(outQueueNonEmpty))
    else $error("output queue summary wrong in status byte");

  a_poll_request: assert property (@(posedge clk) disable iff (!rst_n)
    serialPoll |=> pollByte[SB_SUMM] == $past(srqOut))
    else $error("poll byte does not carry request flag");

  a_poll_outq: assert property (@(posedge clk) disable iff (!rst_n)
    serialPoll |=> pollByte[SB_OUTQ] == $past(outQueueNonEmpty))
    else $error("poll byte output queue bit wrong");

  a_srq_held: assert property (@(posedge clk) disable iff (!rst_n)
    (srqOut && !serialPoll) |=> srqOut)
    else $error("request flag dropped without serial poll");

  a_srq_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (!srqOut && !sumRise) |=> !srqOut)
    else $error("request flag raised without summary rise");

  // Register writes and reads
  a_mask_write: assert property (@(posedge clk) disable iff (!rst_n)
    (wrEn && wrSel == SEL_SRE) |=> srMask == $past(wrData[SBSR_BYTE_W-1:0]))
    else $error("service request mask write lost");

  a_std_ena_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (wrEn && wrSel == SEL_STD_ENA && wrData == SBSR_REG_RST) |=> stdEna == SBSR_REG_RST)
    else $error("zero write left standard enable bits");

  a_ena_write: assert property (@(posedge clk) disable iff (!rst_n)
    (wrEn && wrSel == SEL_OPR_ENA) |=> oprEna == ($past(wrData) & SBSR_TOP_MASK))
    else $error("operation enable write not bit-weighted");

  a_evt_readonly: assert property (@(posedge clk) disable iff (!rst_n)
    (wrEn && wrSel == SEL_OPR_EVT && src.operEvent == SBSR_REG_RST && !evtClear)
      |=> $stable(oprEvt))
    else $error("event register took a host write");

  a_err_preset: assert property (@(posedge clk) disable iff (!rst_n)
    (cmd.statusPreset && !errClear && !errQueuePush) |=> $stable(errQueueNonEmpty))
    else $error("status preset disturbed error queue");

  a_clr_keeps_ena: assert property (@(posedge clk) disable iff (!rst_n)
    (evtClear && !wrEn && !cmd.statusPreset)
      |=> ($stable(stdEna) && $stable(oprEna) && $stable(meaEna) && $stable(queEna)))
    else $error("clear status disturbed enable bits");

  a_std_evt_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    (stdEvt[0] && !evtClear && !(rdEn && rdSel == SEL_STD_EVT))
      |=> stdEvt[0])
    else $error("standard event bit dropped without clear");

  a_cond_read: assert property (@(posedge clk) disable iff (!rst_n)
    (rdEn && rdSel == SEL_MEA_COND) |=> rdData == ($past(src.measCond) & SBSR_TOP_MASK))
    else $error("condition query value wrong");

  a_std_read_data: assert property (@(posedge clk) disable iff (!rst_n)
    (rdEn && rdSel == SEL_STD_EVT) |=> rdData == $past(stdEvt))
    else $error("standard event query value wrong");

endmodule : sbsr_status_byte

// [sbsr_status_byte_test.sv]
// Testbench: drives the status byte block as a remote controller and checks results
`timescale 1ns/10ps
module sbsr_status_byte_test;
  import sbsr_pkg::*;
  logic        clk;
  logic        arst_n;
  sbsr_cmd_t   cmd;
  sbsr_src_t   src;
  logic        errQueuePush;
  logic        outQueueNonEmpty;
  logic        wrEn;
  sbsr_sel_t   wrSel;
  logic [15:0] wrData;
  logic        rdEn;
  sbsr_sel_t   rdSel;
  logic        serialPoll;
  logic [15:0] rdData;
  logic [7:0]  pollByte;
  logic        srqOut;
  logic        errQueueNonEmpty;
  logic [7:0]  pb;
  int          failures;
  int          totalChecks;
  sbsr_sel_t   enaSel [4] = '{SEL_STD_ENA, SEL_OPR_ENA, SEL_MEA_ENA, SEL_QUE_ENA};
  logic [5:0]  clrCmd [3] = '{6'h08, 6'h04, 6'h20};

  sbsr_status_byte dut (.clk(clk), .arst_n(arst_n), .cmd(cmd), .src(src),
    .errQueuePush(errQueuePush), .outQueueNonEmpty(outQueueNonEmpty), .wrEn(wrEn),
    .wrSel(wrSel), .wrData(wrData), .rdEn(rdEn), .rdSel(rdSel), .serialPoll(serialPoll),
    .rdData(rdData), .pollByte(pollByte), .srqOut(srqOut),
    .errQueueNonEmpty(errQueueNonEmpty));
  sbsr_host_model host (.clk(clk), .cmd(cmd), .wrEn(wrEn), .wrSel(wrSel), .wrData(wrData),
    .rdEn(rdEn), .rdSel(rdSel), .serialPoll(serialPoll), .rdData(rdData),
    .pollByte(pollByte));

  always #2.5 clk = ~clk;

  task automatic finish_test;
    $display("checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic expect_reg(input sbsr_sel_t sel, input logic [15:0] exp);
    logic [15:0] got;
    host.read_reg(sel, got);
    check(sel.name(), got, exp);
  endtask : expect_reg

  // Bounded wait; running out is a failure and ends the run
  task automatic wait_srq;
    for (int i = 0; i < 8 && srqOut !== 1'b1; i++) begin
      @(negedge clk);
    end
    if (srqOut !== 1'b1) begin
      failures++;
      finish_test();
    end
  endtask : wait_srq

  task automatic pulse_err;
    @(negedge clk);
    errQueuePush = 1'b1;
    @(negedge clk);
    errQueuePush = 1'b0;
  endtask : pulse_err

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    src = '0;
    errQueuePush = 1'b0;
    outQueueNonEmpty = 1'b0;
    failures = 0;
    totalChecks = 0;
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    check("srqOut", {15'h0000, srqOut}, 16'h0000);
    check("errQueueNonEmpty", {15'h0000, errQueueNonEmpty}, 16'h0000);
    expect_reg(SEL_SRE, 16'h0000);
    expect_reg(SEL_STB, 16'h0000);
    host.write_reg(SEL_SRE, 16'h00FF);
    expect_reg(SEL_SRE, 16'h00FF);
    host.write_reg(SEL_SRE, 16'h0000);
    expect_reg(SEL_SRE, 16'h0000);
    foreach (enaSel[i]) begin
      expect_reg(enaSel[i], 16'h0000);
      host.write_reg(enaSel[i], 16'hFFFF);
      expect_reg(enaSel[i], 16'h7FFF);
      host.write_reg(enaSel[i], 16'h0000);
      expect_reg(enaSel[i], 16'h0000);
      host.write_reg(enaSel[i], 16'h001A);
      expect_reg(enaSel[i], 16'h001A);
      host.write_reg(enaSel[i], 16'h7FFF);
    end
    host.write_reg(SEL_OPR_EVT, 16'h1234);
    host.write_reg(SEL_STB, 16'h00FF);
    expect_reg(SEL_OPR_EVT, 16'h0000);
    expect_reg(SEL_STB, 16'h0000);
    @(negedge clk);
    src.stdEvent = 16'h0001;
    src.operEvent = 16'h0001;
    src.measEvent = 16'h0001;
    src.quesEvent = 16'h0001;
    @(negedge clk);
    src = '0;
    expect_reg(SEL_STB, 16'h00A9);
    expect_reg(SEL_OPR_EVT, 16'h0001);
    host.write_reg(SEL_SRE, 16'h0040);
    expect_reg(SEL_STB, 16'h00A9);
    host.write_reg(SEL_SRE, 16'h0001);
    wait_srq();
    expect_reg(SEL_STB, 16'h00E9);
    host.poll(pb);
    check("pollByte", {8'h00, pb}, 16'h00E9);
    check("srqOut", {15'h0000, srqOut}, 16'h0000);
    expect_reg(SEL_STB, 16'h00E9);
    host.poll(pb);
    check("pollByte", {8'h00, pb}, 16'h00A9);
    host.pulse(6'h02);
    host.pulse(6'h01);
    expect_reg(SEL_STB, 16'h00E9);
    expect_reg(SEL_OPR_ENA, 16'h7FFF);
    host.write_reg(SEL_SRE, 16'h0005);
    pulse_err();
    check("errQueueNonEmpty", {15'h0000, errQueueNonEmpty}, 16'h0001);
    wait_srq();
    expect_reg(SEL_STB, 16'h00ED);
    host.poll(pb);
    check("pollByte", {8'h00, pb}, 16'h00ED);
    host.write_reg(SEL_SRE, 16'h0001);
    host.pulse(6'h10);
    for (int i = 1; i < 4; i++) begin
      expect_reg(enaSel[i], 16'h0000);
    end
    expect_reg(SEL_STD_ENA, 16'h7FFF);
    expect_reg(SEL_SRE, 16'h0001);
    check("errQueueNonEmpty", {15'h0000, errQueueNonEmpty}, 16'h0001);
    expect_reg(SEL_STB, 16'h0024);
    expect_reg(SEL_STD_EVT, 16'h0001);
    expect_reg(SEL_STB, 16'h0004);
    foreach (clrCmd[i]) begin
      pulse_err();
      host.pulse(clrCmd[i]);
      check("errQueueNonEmpty", {15'h0000, errQueueNonEmpty}, 16'h0000);
    end
    expect_reg(SEL_OPR_EVT, 16'h0000);
    expect_reg(SEL_MEA_EVT, 16'h0000);
    expect_reg(SEL_QUE_EVT, 16'h0000);
    expect_reg(SEL_SRE, 16'h0001);
    host.write_reg(SEL_SRE, 16'h0010);
    @(negedge clk);
    outQueueNonEmpty = 1'b1;
    wait_srq();
    expect_reg(SEL_STB, 16'h0050);
    outQueueNonEmpty = 1'b0;
    expect_reg(SEL_STB, 16'h0000);
    finish_test();
  end
endmodule : sbsr_status_byte_test
